// ---- hw/hltc_timer.sv ----
/*
 * Control and configuration logic of an 8-bit period timer with hardware
 * limit: register map, clock and reset source selection, edge polarity,
 * prescaler and postscaler, run-bit synchronisation, interrupt flag.
 * Assumes all inputs are synchronous to CLK; clock sources arrive as
 * levels sampled on CLK and are edge-detected here.
 */
`timescale 1ns/1ps

import hltc_pkg::*;

module hltc_timer (
  // clock and reset
  input  wire logic               CLK,
  input  wire logic               ARST_N,
  // register port
  input  wire hltc_pkg::hltc_bus_req_t BUS,
  output logic [7:0]              RDATA,
  // clock and reset sources
  input  wire hltc_pkg::hltc_clk_in_t  CLK_SRC,
  input  wire hltc_pkg::hltc_rst_in_t  RST_SRC,
  input  wire logic               SLEEP,
  // results
  output logic                    MATCH_OUT,
  output logic                    IRQ
);
  import hltc_pkg::*;

  logic [7:0] count;
  logic [7:0] period;
  logic [7:0] ctrl;
  logic [7:0] hlt;
  logic [2:0] clksrc;
  logic [3:0] rstsel;
  logic       irq_st;
  logic       irq_msk;

  logic [1:0] instr_div;
  logic       instr_tick;
  logic       sel_lvl;
  logic       sel_q;
  logic       in_edge;
  logic [6:0] pre_cnt;
  logic       pre_out;
  logic       pre_sync;
  logic       tick;
  logic [1:0] on_sync;
  logic       run;
  logic       ext_rst;
  logic       ext_q;
  logic       match;
  logic [3:0] post_cnt;
  logic       post_ev;
  logic       hw_clear;
  logic       sw_on_wr;
  logic [4:0] mode;
  logic       wr_count;
  logic       wr_period;
  logic       wr_hlt;
  logic       wr_clksrc;
  logic       wr_rstsel;
  logic       wr_irqst;
  logic       wr_irqmsk;
  logic       ext_rise;

  assign mode     = hlt[4:0];
  assign sw_on_wr = BUS.wr && (BUS.addr == HLTC_OFF_CTRL);

  // one write decode per register; unmapped addresses match none
  assign wr_count  = BUS.wr && (BUS.addr == HLTC_OFF_COUNT);
  assign wr_period = BUS.wr && (BUS.addr == HLTC_OFF_PERIOD);
  assign wr_hlt    = BUS.wr && (BUS.addr == HLTC_OFF_HLT);
  assign wr_clksrc = BUS.wr && (BUS.addr == HLTC_OFF_CLKSRC);
  assign wr_rstsel = BUS.wr && (BUS.addr == HLTC_OFF_RSTSEL);
  assign wr_irqst  = BUS.wr && (BUS.addr == HLTC_OFF_IRQST);
  assign wr_irqmsk = BUS.wr && (BUS.addr == HLTC_OFF_IRQMSK);

  // instruction clock is the system clock divided by four
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      instr_div <= 2'h0;
    end else begin
      instr_div <= instr_div + 2'h1;
    end
  end
  assign instr_tick = (instr_div == 2'h3);

  always_comb begin
    unique case (hltc_cs_t'(clksrc))
      HLTC_CS_PIN:   sel_lvl = CLK_SRC.pin;
      HLTC_CS_INSTR: sel_lvl = instr_div[1];
      HLTC_CS_SYS:   sel_lvl = ~sel_q;
      HLTC_CS_HFOSC: sel_lvl = CLK_SRC.hfosc;
      HLTC_CS_LFOSC: sel_lvl = CLK_SRC.lfosc;
      HLTC_CS_MF500: sel_lvl = CLK_SRC.mf500;
      HLTC_CS_MF32:  sel_lvl = CLK_SRC.mf32;
      HLTC_CS_RSVD:  sel_lvl = sel_q;
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sel_q <= 1'b0;
    end else begin
      sel_q <= sel_lvl;
    end
  end

  // polarity picks falling or rising edge
  always_comb begin
    if (hlt[HLTC_HLT_INPUT_EDGE_POLARITY_BIT]) begin
      in_edge = sel_q && !sel_lvl;
    end else begin
      in_edge = !sel_q && sel_lvl;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pre_cnt <= 7'h00;
    end else if (!ctrl[HLTC_CTRL_ON_BIT]) begin
      pre_cnt <= 7'h00;
    end else if (in_edge) begin
      pre_cnt <= pre_cnt + 7'h01;
    end
  end

  // prescale ratio 1:2^n from the pre_cnt carry chain
  always_comb begin
    if (ctrl[6:4] == 3'h0) begin
      pre_out = in_edge;
    end else begin
      pre_out = in_edge && (&(pre_cnt | ~((7'h01 << ctrl[6:4]) - 7'h01)));
    end
  end

  // hold prescaler output until an instruction clock tick
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pre_sync <= 1'b0;
    end else if (!ctrl[HLTC_CTRL_ON_BIT]) begin
      pre_sync <= 1'b0;
    end else if (pre_out) begin
      pre_sync <= 1'b1;
    end else if (instr_tick) begin
      pre_sync <= 1'b0;
    end
  end

  // synced timer does not advance during sleep
  always_comb begin
    if (hlt[HLTC_HLT_PRESCALER_OUTPUT_SYNC_BIT]) begin
      tick = pre_sync && instr_tick && !SLEEP;
    end else begin
      tick = pre_out;
    end
  end

  // run bit passes two timer input clocks before use
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      on_sync <= 2'h0;
    end else if (!ctrl[HLTC_CTRL_ON_BIT]) begin
      // a stale stage would let a quick off-on skip the start delay
      on_sync <= 2'h0;
    end else if (in_edge) begin
      on_sync <= {on_sync[0], ctrl[HLTC_CTRL_ON_BIT]};
    end
  end

  assign run = hlt[HLTC_HLT_ENABLE_TO_CLOCK_SYNC_BIT] ? (on_sync[1] && ctrl[HLTC_CTRL_ON_BIT])
                                       : ctrl[HLTC_CTRL_ON_BIT];

  // external reset source mux, reserved codes read low
  always_comb begin
    unique case (rstsel)
      4'h0:    ext_rst = RST_SRC.pin;
      4'h1:    ext_rst = RST_SRC.capcomp1;
      4'h2:    ext_rst = RST_SRC.capcomp2;
      4'h3:    ext_rst = RST_SRC.pulse3;
      4'h4:    ext_rst = RST_SRC.pulse4;
      default: ext_rst = 1'b0;
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= ext_rst;
    end
  end

  // only a rising edge of the chosen source counts, and only while on
  assign ext_rise = ctrl[HLTC_CTRL_ON_BIT] && (mode != 5'h00) && !ext_q && ext_rst;

  assign match = tick && run && (count == period);

  // modes that self-clear run on a period match
  always_comb begin
    unique case (mode)
      HLTC_MODE_OS_SW, HLTC_MODE_OS_EDGE, HLTC_MODE_OS_EDGE2,
      HLTC_MODE_MONO_LO, HLTC_MODE_MONO_HI: hw_clear = match;
      default:                              hw_clear = 1'b0;
    endcase
  end

  // run bit is cleared by hardware in one-shot modes
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl <= HLTC_RST_CTRL;
    end else if (sw_on_wr) begin
      ctrl <= BUS.wdata;
    end else if (hw_clear) begin
      ctrl[HLTC_CTRL_ON_BIT] <= 1'b0;
    end
  end

  // count advances only while running, held otherwise
  // period match clears count on the same timer clock
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      count <= HLTC_RST_COUNT;
    end else if (wr_count) begin
      count <= BUS.wdata;
    end else if (ext_rise) begin
      // a rising edge on the selected reset source clears the count to zero
      count <= 8'h00;
    end else if (tick && run) begin
      count <= (count == period) ? 8'h00 : count + 8'h01;
    end
  end

  // postscaler counts matches up to ratio
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      post_cnt <= 4'h0;
    end else if (!ctrl[HLTC_CTRL_ON_BIT]) begin
      post_cnt <= 4'h0;
    end else if (match) begin
      post_cnt <= (post_cnt == ctrl[3:0]) ? 4'h0 : post_cnt + 4'h1;
    end
  end
  assign post_ev = match && (post_cnt == ctrl[3:0]);

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      period <= HLTC_RST_PERIOD;
    end else if (wr_period) begin
      period <= BUS.wdata;
    end
  end

  // mode field held in limit control
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hlt <= HLTC_RST_HLT;
    end else if (wr_hlt) begin
      hlt <= BUS.wdata;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      clksrc <= HLTC_RST_CLKSRC;
    end else if (wr_clksrc) begin
      clksrc <= BUS.wdata[2:0];
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rstsel <= HLTC_RST_RSTSEL;
    end else if (wr_rstsel) begin
      rstsel <= BUS.wdata[3:0];
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_msk <= 1'b0;
    end else if (wr_irqmsk) begin
      irq_msk <= BUS.wdata[0];
    end
  end

  // sticky flag, set wins over write-one clear
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_st <= 1'b0;
    end else if (post_ev) begin
      irq_st <= 1'b1;
    end else if (wr_irqst && BUS.wdata[0]) begin
      irq_st <= 1'b0;
    end
  end

  // count is read from the CLK-domain register, always settled
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= 8'h00;
    end else if (BUS.rd) begin
      unique case (BUS.addr)
        HLTC_OFF_COUNT:  RDATA <= count;
        HLTC_OFF_PERIOD: RDATA <= period;
        HLTC_OFF_CTRL:   RDATA <= ctrl;
        HLTC_OFF_HLT:    RDATA <= hlt;
        HLTC_OFF_CLKSRC: RDATA <= {5'h00, clksrc};
        HLTC_OFF_RSTSEL: RDATA <= {4'h0, rstsel};
        HLTC_OFF_IRQST:  RDATA <= {7'h00, irq_st};
        HLTC_OFF_IRQMSK: RDATA <= {7'h00, irq_msk};
        default:         RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      MATCH_OUT <= 1'b0;
    end else begin
      MATCH_OUT <= post_ev;
    end
  end

  // event folded in so the line rises with the pulse, not a cycle later
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= (irq_st || post_ev) && irq_msk;
    end
  end

endmodule

// ---- hw/hltc_pkg.sv ----
/*
 * Package for the hardware limit timer control block: register offsets,
 * field positions, reset values, encodings and bus carriers.
 * Assumes a plain register port with 12-bit addresses and 8-bit data.
 */
package hltc_pkg;

  // register byte addresses
  localparam logic [11:0] HLTC_OFF_COUNT  = 12'h28c;
  localparam logic [11:0] HLTC_OFF_PERIOD = 12'h28d;
  localparam logic [11:0] HLTC_OFF_CTRL   = 12'h28e;
  localparam logic [11:0] HLTC_OFF_HLT    = 12'h28f;
  localparam logic [11:0] HLTC_OFF_CLKSRC = 12'h290;
  localparam logic [11:0] HLTC_OFF_RSTSEL = 12'h291;
  localparam logic [11:0] HLTC_OFF_IRQST  = 12'h292;
  localparam logic [11:0] HLTC_OFF_IRQMSK = 12'h293;

  // timer_control fields
  localparam int HLTC_CTRL_ON_BIT = 7;
  // hardware_limit_control fields
  localparam int HLTC_HLT_PRESCALER_OUTPUT_SYNC_BIT = 7;
  localparam int HLTC_HLT_INPUT_EDGE_POLARITY_BIT  = 6;
  localparam int HLTC_HLT_ENABLE_TO_CLOCK_SYNC_BIT = 5;

  // reset values
  localparam logic [7:0] HLTC_RST_COUNT  = 8'h00;
  localparam logic [7:0] HLTC_RST_PERIOD = 8'hff;
  localparam logic [7:0] HLTC_RST_CTRL   = 8'h00;
  localparam logic [7:0] HLTC_RST_HLT    = 8'h00;
  localparam logic [2:0] HLTC_RST_CLKSRC = 3'h0;
  localparam logic [3:0] HLTC_RST_RSTSEL = 4'h0;

  // run-bit start delay in timer input clocks with enable sync
  localparam logic [1:0] HLTC_ENABLE_TO_CLOCK_SYNC_CLKS = 2'h2;

  // one-shot mode codes that self-clear the run bit on period match
  localparam logic [4:0] HLTC_MODE_OS_SW    = 5'h08;
  localparam logic [4:0] HLTC_MODE_OS_EDGE  = 5'h0e;
  localparam logic [4:0] HLTC_MODE_OS_EDGE2 = 5'h0f;
  localparam logic [4:0] HLTC_MODE_MONO_LO  = 5'h11;
  localparam logic [4:0] HLTC_MODE_MONO_HI  = 5'h13;

  // clock source codes
  typedef enum logic [2:0] {
    HLTC_CS_PIN   = 3'h0,
    HLTC_CS_INSTR = 3'h1,
    HLTC_CS_SYS   = 3'h2,
    HLTC_CS_HFOSC = 3'h3,
    HLTC_CS_LFOSC = 3'h4,
    HLTC_CS_MF500 = 3'h5,
    HLTC_CS_MF32  = 3'h6,
    HLTC_CS_RSVD  = 3'h7
  } hltc_cs_t;

  localparam logic [3:0] HLTC_RS_LAST = 4'h4;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } hltc_bus_req_t;

  // candidate clock levels: pin, hf, lf, 500k, 32k (instr and sys made inside)
  typedef struct packed {
    logic pin;
    logic hfosc;
    logic lfosc;
    logic mf500;
    logic mf32;
  } hltc_clk_in_t;

  typedef struct packed {
    logic pin;
    logic capcomp1;
    logic capcomp2;
    logic pulse3;
    logic pulse4;
  } hltc_rst_in_t;

endpackage

// ---- test/hltc_timer_properties.sv ----
/*
 * Concurrent checks on the ports of hltc_timer, bound after the module.
 * Assumes the one CLK domain and a bus master that never overlaps strobes.
 */
`timescale 1ns/1ps
module hltc_timer_properties (
  // clock and reset
  input wire logic                    CLK,
  input wire logic                    ARST_N,
  // register port
  input wire hltc_pkg::hltc_bus_req_t BUS,
  input wire logic [7:0]              RDATA,
  // results
  input wire logic                    MATCH_OUT,
  input wire logic                    IRQ
);
  import hltc_pkg::*;
  logic msk;
  logic csy;
  wire  wr_per = BUS.wr && BUS.addr == HLTC_OFF_PERIOD;
  wire  rd_per = BUS.rd && BUS.addr == HLTC_OFF_PERIOD;
  wire  wr_hlt = BUS.wr && BUS.addr == HLTC_OFF_HLT;
  wire  rd_hlt = BUS.rd && BUS.addr == HLTC_OFF_HLT;
  wire  wr_ctl = BUS.wr && BUS.addr == HLTC_OFF_CTRL;

  // mirror of software mask and run-sync bit, needed as antecedents
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      msk <= 1'b0;
      csy <= 1'b0;
    end else begin
      if (BUS.wr && BUS.addr == HLTC_OFF_IRQMSK) msk <= BUS.wdata[0];
      if (wr_hlt) csy <= BUS.wdata[HLTC_HLT_ENABLE_TO_CLOCK_SYNC_BIT];
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  property p_rd_idle; !$past(BUS.rd) |-> RDATA == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_unmapped;
    $past(BUS.rd) && ($past(BUS.addr) < HLTC_OFF_COUNT || $past(BUS.addr) > HLTC_OFF_IRQMSK)
      |-> RDATA == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_period_rb; wr_per ##2 rd_per |=> RDATA == $past(BUS.wdata, 3); endproperty
  a_period_rb: assert property (p_period_rb) else $error("period readback wrong");
  property p_hlt_rb; wr_hlt ##2 rd_hlt |=> RDATA == $past(BUS.wdata, 3); endproperty
  a_hlt_rb: assert property (p_hlt_rb) else $error("limit control readback wrong");
  property p_match_pulse; MATCH_OUT |=> !MATCH_OUT; endproperty
  a_match_pulse: assert property (p_match_pulse) else $error("match pulse too long");
  property p_irq_follow; MATCH_OUT && msk |-> ##[0:1] IRQ; endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("irq missed a match");
  property p_irq_masked; !msk && !$past(msk) |-> !IRQ; endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq while masked");
  property p_off_quiet;
    wr_ctl && !BUS.wdata[HLTC_CTRL_ON_BIT] && !csy ##1 !wr_ctl [*2] |=> ##1 !MATCH_OUT [*2];
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("match after timer off");
endmodule

bind hltc_timer hltc_timer_properties u_props (
  .CLK       (CLK),
  .ARST_N    (ARST_N),
  .BUS       (BUS),
  .RDATA     (RDATA),
  .MATCH_OUT (MATCH_OUT),
  .IRQ       (IRQ)
);

// ---- test/hltc_src_model.sv ----
/*
 * Far-side sources of hltc_timer: free-running oscillator and pin clock
 * levels at fixed ratios of CLK, and reset-source levels.
 * Assumes the bench supplies CLK, ARST_N and the reset level.
 */
`timescale 1ns/1ps
module hltc_src_model (
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              ARST_N,
  // reset level to present
  input  wire logic              rst_lvl,
  // source levels
  output hltc_pkg::hltc_clk_in_t clk_src,
  output hltc_pkg::hltc_rst_in_t rst_src
);
  import hltc_pkg::*;
  logic [4:0] cnt;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) cnt <= 5'h00;
    else cnt <= cnt + 5'h01;
  end
  // internal oscillators never stop, so they run free; rising edges every 4/2/16/8/32
  assign clk_src = '{pin: cnt[1], hfosc: cnt[0], lfosc: cnt[3], mf500: cnt[2], mf32: cnt[4]};
  assign rst_src = {5{rst_lvl}};
endmodule

// ---- test/hltc_timer_tb.sv ----
/*
 * Self-checking bench for hltc_timer: register map, clock sources,
 * prescale/postscale intervals, interrupt, self-clear, sleep.
 * Assumes hltc_src_model as the far side and the register port timing.
 */
`timescale 1ns/1ps
module hltc_timer_tb;
  import hltc_pkg::*;
  logic          CLK, ARST_N, SLEEP, MATCH_OUT, IRQ, rst_lvl;
  logic [7:0]    RDATA, rd_v;
  hltc_bus_req_t bus;
  hltc_clk_in_t  csrc;
  hltc_rst_in_t  rsrc;
  int            err_total, n_tests, seed, p, r, ck, g, i;
  int            div [8] = '{4, 4, 2, 2, 16, 8, 32, 0};
  logic [7:0]    rst_exp [8] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  hltc_timer dut (.CLK(CLK), .ARST_N(ARST_N), .BUS(bus), .RDATA(RDATA), .CLK_SRC(csrc),
    .RST_SRC(rsrc), .SLEEP(SLEEP), .MATCH_OUT(MATCH_OUT), .IRQ(IRQ));
  hltc_src_model src (.CLK(CLK), .ARST_N(ARST_N), .rst_lvl(rst_lvl), .clk_src(csrc),
    .rst_src(rsrc));

  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge CLK);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge CLK);
    bus.wr <= 1'b0;
  endtask
  task rd(input logic [11:0] a);
    @(posedge CLK);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge CLK);
    bus.rd <= 1'b0;
    @(negedge CLK);
    rd_v = RDATA;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task rchk(input logic [11:0] a, input logic [7:0] e);
    rd(a);
    chk("reg", {8'h00, e}, {8'h00, rd_v});
  endtask
  task wait_pulse(output int t);
    t = 0;
    do begin
      @(negedge CLK);
      t++;
    end while (MATCH_OUT !== 1'b1 && t < 5000);
  endtask
  task quiet(output int n);
    n = 0;
    repeat (300) begin
      @(negedge CLK);
      n += (MATCH_OUT !== 1'b0);
    end
  endtask
  task test_done;
    $display("mismatches %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // generous bound: the interval sweep needs at most about 5k cycles
  initial begin
    repeat (80000) @(posedge CLK);
    err_total++;
    test_done;
  end

  initial begin
    seed = 37;
    err_total = 0;
    n_tests = 0;
    ARST_N = 1'b0;
    SLEEP = 1'b0;
    rst_lvl = 1'b0;
    bus = '0;
    repeat (2) @(posedge CLK);
    ARST_N <= 1'b1;
    for (i = 0; i < 8; i++) rchk(HLTC_OFF_COUNT + i[11:0], rst_exp[i]);
    rchk(12'h2a0, 8'h00);
    g = $random(seed);
    wr(HLTC_OFF_PERIOD, g[7:0]);
    rchk(HLTC_OFF_PERIOD, g[7:0]);
    wr(HLTC_OFF_HLT, g[15:8]);
    rchk(HLTC_OFF_HLT, g[15:8]);
    wr(HLTC_OFF_CLKSRC, g[23:16]);
    rchk(HLTC_OFF_CLKSRC, {5'h00, g[18:16]});
    wr(HLTC_OFF_RSTSEL, g[31:24]);
    rchk(HLTC_OFF_RSTSEL, {4'h0, g[27:24]});
    wr(HLTC_OFF_IRQMSK, 8'h01);
    for (i = 0; i < 8; i++) begin
      p = $random(seed) & 3;
      r = (i == 2) ? 15 : $random(seed) & 3;
      ck = $random(seed) & 1;
      g = $random(seed);
      wr(HLTC_OFF_CTRL, 8'h00);
      wr(HLTC_OFF_HLT, {1'b0, g[0], g[1], 5'h00});
      wr(HLTC_OFF_CLKSRC, i[7:0]);
      wr(HLTC_OFF_PERIOD, p[7:0]);
      // stopping keeps the count, so each interval starts from zero
      wr(HLTC_OFF_COUNT, 8'h00);
      wr(HLTC_OFF_CTRL, {1'b1, ck[2:0], r[3:0]});
      if (i == 7) begin
        quiet(g);
        chk("pulses", 16'h0000, g[15:0]);
      end else begin
        wait_pulse(g);
        wait_pulse(g);
        chk("gap", (div[i] * (p + 1) * (r + 1)) << ck, g[15:0]);
      end
    end
    wr(HLTC_OFF_CTRL, 8'h00);
    @(negedge CLK);
    chk("irq", 16'h0001, {15'h0000, IRQ});
    rchk(HLTC_OFF_IRQST, 8'h01);
    wr(HLTC_OFF_IRQMSK, 8'h00);
    repeat (2) @(negedge CLK);
    chk("irq", 16'h0000, {15'h0000, IRQ});
    wr(HLTC_OFF_IRQMSK, 8'h01);
    repeat (2) @(negedge CLK);
    chk("irq", 16'h0001, {15'h0000, IRQ});
    wr(HLTC_OFF_IRQST, 8'h01);
    repeat (2) @(negedge CLK);
    chk("irq", 16'h0000, {15'h0000, IRQ});
    rchk(HLTC_OFF_IRQST, 8'h00);
    wr(HLTC_OFF_HLT, {3'h0, HLTC_MODE_OS_SW});
    wr(HLTC_OFF_CLKSRC, 8'h01);
    wr(HLTC_OFF_PERIOD, 8'h02);
    wr(HLTC_OFF_CTRL, 8'h80);
    wait_pulse(g);
    repeat (2) @(negedge CLK);
    rchk(HLTC_OFF_CTRL, 8'h00);
    @(posedge CLK);
    SLEEP <= 1'b1;
    wr(HLTC_OFF_HLT, 8'h80);
    wr(HLTC_OFF_CTRL, 8'h80);
    quiet(g);
    chk("pulses", 16'h0000, g[15:0]);
    rchk(HLTC_OFF_COUNT, 8'h00);
    @(posedge CLK);
    SLEEP <= 1'b0;
    wait_pulse(g);
    chk("wake", 16'h0001, {15'h0000, MATCH_OUT});
    wait_pulse(g);
    chk("sync gap", div[1] * 3, g[15:0]);
    wr(HLTC_OFF_CTRL, 8'h00);
    wr(HLTC_OFF_HLT, 8'h01);
    wr(HLTC_OFF_PERIOD, 8'hff);
    // pin source clears the count on a rising edge, reserved code never does
    for (i = 0; i < 2; i++) begin
      wr(HLTC_OFF_RSTSEL, (i == 0) ? 8'h00 : 8'h05);
      wr(HLTC_OFF_COUNT, 8'h00);
      wr(HLTC_OFF_CTRL, 8'h80);
      repeat (200) @(posedge CLK);
      rst_lvl <= 1'b1;
      wr(HLTC_OFF_CTRL, 8'h00);
      rst_lvl <= 1'b0;
      rd(HLTC_OFF_COUNT);
      chk("ext rst", {15'h0000, i == 0}, {15'h0000, rd_v < 8'h04});
      rchk(HLTC_OFF_COUNT, rd_v);
    end
    @(posedge CLK);
    ARST_N <= 1'b0;
    @(posedge CLK);
    ARST_N <= 1'b1;
    rchk(HLTC_OFF_CTRL, 8'h00);
    test_done;
  end
endmodule
